//--- hw/keypad_pkg.sv
// Purpose: shared constants and types for the key repeat, sleep and port block
// Assumes: 20 MHz system clock, byte-wide register port
// Notes:   register offsets are the byte addresses seen by the serial engine
package keypad_pkg;

  // register offsets
  localparam logic [7:0] REG_CFG    = 8'h01;
  localparam logic [7:0] REG_DEB    = 8'h02;
  localparam logic [7:0] REG_PORTS  = 8'h04;
  localparam logic [7:0] REG_REPEAT = 8'h05;
  localparam logic [7:0] REG_SLEEP  = 8'h06;

  // field positions and widths
  localparam int CFG_RUN_BIT   = 7;
  localparam int CFG_WAKE_BIT  = 1;
  localparam int REP_EN_BIT    = 7;
  localparam int REP_RATE_LSB  = 4;
  localparam int REP_RATE_W    = 3;
  localparam int REP_DELAY_LSB = 0;
  localparam int REP_DELAY_W   = 4;
  localparam int DEB_TIME_LSB  = 0;
  localparam int DEB_TIME_W    = 5;
  localparam int DEB_PORTS_LSB = 5;
  localparam int DEB_PORTS_W   = 3;
  localparam int SLEEP_CODE_W  = 3;

  // reset values and masks
  localparam logic [7:0] PORTS_RST   = 8'hFE;
  localparam logic [7:0] PORTS_MASK  = 8'hFE;
  localparam logic [7:0] REPEAT_RST  = 8'h00;
  localparam logic [7:0] DEB_RST     = 8'hFF;
  localparam logic [2:0] SLEEP_RST   = 3'h7;
  localparam logic       CFG_RUN_RST = 1'b1;
  localparam logic       CFG_WAKE_RST = 1'b1;

  // codes
  localparam logic [7:0] REPEAT_CODE     = 8'h7E;
  localparam logic [2:0] SLEEP_OFF_CODE  = 3'h0;
  localparam logic [2:0] SLEEP_LAST_CODE = 3'h7;

  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_PERIOD_NS  = 1000000;
  localparam int CYCLES_PER_MS = (MS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_TIME_MS  = 2;
  localparam int DEB_BASE_MS   = 9;
  localparam int SLEEP_MAX_MS  = 8192;
  localparam int DELAY_STEP    = 8;
  localparam int RATE_STEP     = 4;

  typedef enum logic [1:0] {st_run, st_sleep, st_waking} sleep_state_t;

endpackage

//--- hw/tick_if.sv
// Purpose: carries the millisecond and debounce ticks inside the block
// Assumes: single clock domain
// Notes:   the debounce code flows back to the tick source
`timescale 1ns/10ps
`default_nettype none
interface tick_if;
  logic       ms_tick;
  logic       debounce_tick;
  logic [4:0] debounce_code;
  modport gen  (input debounce_code, output ms_tick, output debounce_tick);
  modport sink (output debounce_code, input ms_tick, input debounce_tick);
endinterface
`default_nettype wire

//--- hw/tick_gen.sv
// Purpose: millisecond tick and programmable debounce-cycle tick
// Assumes: CYCLES_PER_MS clocks make one millisecond
// Notes:   debounce tick coincides with a millisecond tick
`timescale 1ns/10ps
`default_nettype none
module tick_gen #(
  parameter int CYCLES_PER_MS = keypad_pkg::CYCLES_PER_MS
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // tick carrier
  tick_if.gen       ticks
);
  localparam int MS_W = $clog2(CYCLES_PER_MS + 1);

  logic [MS_W-1:0] ms_cnt_reg;
  logic [5:0]      deb_cnt_reg;
  logic            ms_tick_reg;
  logic            deb_tick_reg;

  // >= so that lowering the code mid-count cannot run the counter away
  wire            ms_wrap  = (ms_cnt_reg == MS_W'(CYCLES_PER_MS - 1));
  wire [5:0]      deb_last = 6'(keypad_pkg::DEB_BASE_MS - 1) + {1'b0, ticks.debounce_code};
  wire            deb_wrap = ms_wrap && (deb_cnt_reg >= deb_last);
  wire [MS_W-1:0] ms_inc   = ms_cnt_reg + MS_W'(1);

  // base counters; one debounce cycle is 9 ms plus the code
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ms_cnt_reg   <= '0;
      deb_cnt_reg  <= 6'h00;
      ms_tick_reg  <= 1'b0;
      deb_tick_reg <= 1'b0;
    end else begin
      ms_cnt_reg   <= ms_wrap ? '0 : ms_inc;
      ms_tick_reg  <= ms_wrap;
      deb_tick_reg <= deb_wrap;
      if (ms_wrap) begin
        deb_cnt_reg <= deb_wrap ? 6'h00 : deb_cnt_reg + 6'h01;
      end
    end
  end

  assign ticks.ms_tick       = ms_tick_reg;
  assign ticks.debounce_tick = deb_tick_reg;

  property p_deb_on_ms;
    @(posedge clk_sys) disable iff (reset)
    ticks.debounce_tick |-> ticks.ms_tick;
  endproperty
  a_deb_on_ms: assert property (p_deb_on_ms) else $error("debounce tick off ms grid");

endmodule
`default_nettype wire

//--- hw/gpo_drive.sv
// Purpose: open-drain general output drive for ports 2..7 and the alert pin
// Assumes: index 0 is the alert line, index k is port k+1
// Notes:   lines not in output mode are left to the scanner
`timescale 1ns/10ps
`default_nettype none
module gpo_drive (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // configuration
  input  wire logic [6:0] level_bits,
  input  wire logic [2:0] ports_code,
  input  wire logic       int_reg_zero,
  // line control
  output logic      [6:0] gpo_mode,
  output logic      [6:0] line_oe
);
  logic [6:0] line_oe_reg;
  wire  [6:0] mode_w;

  // codes 6 and 7 both enable all six ports
  wire [2:0] n_ports = (ports_code > 3'h6) ? 3'h6 : ports_code;

  // per line mode: ports enable from 7 downward
  genvar i;
  generate
    for (i = 0; i < 7; i++) begin : g_line
      if (i == 0) begin : g_alert
        assign mode_w[i] = int_reg_zero;
      end else begin : g_port
        assign mode_w[i] = (3'(6 - i) < n_ports);
      end
    end
  endgenerate

  // one driver for the whole output variable
  assign gpo_mode = mode_w;

  // a zero bit pulls low only in output mode
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      line_oe_reg <= 7'h00;
    end else begin
      line_oe_reg <= gpo_mode & ~level_bits;
    end
  end

  assign line_oe = line_oe_reg;

  property p_no_foreign_drive;
    @(posedge clk_sys) disable iff (reset)
    ##1 ((line_oe & ~$past(gpo_mode)) == 7'h00);
  endproperty
  a_no_foreign_drive: assert property (p_no_foreign_drive) else $error("drive on non-output line");

endmodule
`default_nettype wire

//--- hw/keypad_repeat_sleep_gpo.sv
// Purpose: key autorepeat, sleep control and open-drain outputs
// Assumes: scanner, fifo and serial engine sit outside on clk_sys
// Notes:   register port is a plain byte strobe port from the serial engine
`timescale 1ns/10ps
`default_nettype none
module keypad_repeat_sleep_gpo #(
  parameter int CYCLES_PER_MS = keypad_pkg::CYCLES_PER_MS
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // register port from the serial engine
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // from the interrupt register
  input  wire logic       int_reg_zero,
  // key scanner
  input  wire logic       key_event,
  input  wire logic       any_key_held,
  output logic            debounce_tick,
  output logic            scan_enable,
  // wake sense pin, low while a key is pressed
  input  wire logic       key_wake_n,
  // fifo push side
  output logic            fifo_push,
  output logic      [7:0] fifo_data,
  output logic            repeat_active,
  // matrix analog control
  output logic            sense_enable,
  output logic            matrix_pullup,
  // open-drain lines
  output logic      [5:0] column_or_output_lines_out,
  output logic      [5:0] column_or_output_lines_oe,
  output logic            general_output_line_out,
  output logic            general_output_line_oe,
  output logic      [6:0] gpo_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0]  ports_reg;
  logic [7:0]  repeat_reg;
  logic [7:0]  deb_reg;
  logic [2:0]  sleep_code_reg;
  logic        autowake_reg;
  logic [7:0]  rdata_reg;
  logic        rvalid_reg;

  keypad_pkg::sleep_state_t state_reg;
  keypad_pkg::sleep_state_t state_next;

  // write decode
  wire wr_cfg    = reg_wr && (reg_addr == keypad_pkg::REG_CFG);
  wire wr_deb    = reg_wr && (reg_addr == keypad_pkg::REG_DEB);
  wire wr_ports  = reg_wr && (reg_addr == keypad_pkg::REG_PORTS);
  wire wr_repeat = reg_wr && (reg_addr == keypad_pkg::REG_REPEAT);
  wire wr_sleep  = reg_wr && (reg_addr == keypad_pkg::REG_SLEEP);
  wire wr_run    = reg_wdata[keypad_pkg::CFG_RUN_BIT];

  wire awake = (state_reg == keypad_pkg::st_run);

  // register storage; reserved bits are dropped on write
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ports_reg      <= keypad_pkg::PORTS_RST;
      repeat_reg     <= keypad_pkg::REPEAT_RST;
      deb_reg        <= keypad_pkg::DEB_RST;
      sleep_code_reg <= keypad_pkg::SLEEP_RST;
      autowake_reg   <= keypad_pkg::CFG_WAKE_RST;
    end else begin
      if (wr_ports)  ports_reg      <= reg_wdata & keypad_pkg::PORTS_MASK;
      if (wr_repeat) repeat_reg     <= reg_wdata;
      if (wr_deb)    deb_reg        <= reg_wdata;
      if (wr_sleep)  sleep_code_reg <= reg_wdata[keypad_pkg::SLEEP_CODE_W-1:0];
      if (wr_cfg)    autowake_reg   <= reg_wdata[keypad_pkg::CFG_WAKE_BIT];
    end
  end

  // read view; config shows live sleep status
  wire [7:0] cfg_rd = (8'(awake) << keypad_pkg::CFG_RUN_BIT) |
                      (8'(autowake_reg) << keypad_pkg::CFG_WAKE_BIT);
  wire [7:0] rd_mux =
    (reg_addr == keypad_pkg::REG_CFG)    ? cfg_rd :
    (reg_addr == keypad_pkg::REG_DEB)    ? deb_reg :
    (reg_addr == keypad_pkg::REG_PORTS)  ? ports_reg :
    (reg_addr == keypad_pkg::REG_REPEAT) ? repeat_reg :
    (reg_addr == keypad_pkg::REG_SLEEP)  ? {5'h00, sleep_code_reg} :
    8'h00;

  // read data registered one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd;
      if (reg_rd) rdata_reg <= rd_mux;
    end
  end

  assign reg_rdata  = rdata_reg;
  assign reg_rvalid = rvalid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // ticks

  tick_if ticks ();

  assign ticks.debounce_code =
    deb_reg[keypad_pkg::DEB_TIME_LSB +: keypad_pkg::DEB_TIME_W];

  tick_gen #(
    .CYCLES_PER_MS (CYCLES_PER_MS)
  ) u_tick (
    .clk_sys (clk_sys),
    .reset   (reset),
    .ticks   (ticks)
  );

  assign debounce_tick = ticks.debounce_tick;

  ////////////////////////////////////////////////////////////////////////////
  // wake pin synchroniser; stage two and three must agree

  logic wake_s1_reg;
  logic wake_s2_reg;
  logic wake_s3_reg;
  logic wake_lvl_reg;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wake_s1_reg  <= 1'b1;
      wake_s2_reg  <= 1'b1;
      wake_s3_reg  <= 1'b1;
      wake_lvl_reg <= 1'b1;
    end else begin
      wake_s1_reg <= key_wake_n;
      wake_s2_reg <= wake_s1_reg;
      wake_s3_reg <= wake_s2_reg;
      if (wake_s2_reg == wake_s3_reg) wake_lvl_reg <= wake_s3_reg;
    end
  end

  wire wake_press = !wake_lvl_reg;

  ////////////////////////////////////////////////////////////////////////////
  // idle timer and sleep state

  logic [13:0] idle_ms_reg;
  logic [1:0]  wake_ms_reg;

  // codes 6 and 7 both give the shortest timeout
  wire [2:0]  sleep_shift = (sleep_code_reg == keypad_pkg::SLEEP_LAST_CODE) ?
                            (sleep_code_reg - 3'h2) : (sleep_code_reg - 3'h1);
  wire [13:0] sleep_lim   = 14'(keypad_pkg::SLEEP_MAX_MS) >> sleep_shift;
  wire        sleep_on    = (sleep_code_reg != keypad_pkg::SLEEP_OFF_CODE);
  wire        idle_due    = sleep_on && ticks.ms_tick && !any_key_held &&
                            (idle_ms_reg == sleep_lim - 14'h0001);
  wire        wake_done   = ticks.ms_tick &&
                            (wake_ms_reg == 2'(keypad_pkg::WAKE_TIME_MS - 1));
  wire        idle_clr    = !awake || any_key_held || key_event;

  // idle timer counts whole milliseconds with no key down
  always_ff @(posedge clk_sys) begin
    if (reset || idle_clr) begin
      idle_ms_reg <= 14'h0000;
    end else if (ticks.ms_tick) begin
      idle_ms_reg <= idle_ms_reg + 14'h0001;
    end
  end

  // turn-on delay after a wake press, counted in milliseconds
  always_ff @(posedge clk_sys) begin
    if (reset || (state_reg != keypad_pkg::st_waking)) begin
      wake_ms_reg <= 2'h0;
    end else if (ticks.ms_tick) begin
      wake_ms_reg <= wake_ms_reg + 2'h1;
    end
  end

  // host writes take priority over automatic transitions, except a run write arriving with idle_due in st_run
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      keypad_pkg::st_run: begin
        if (wr_cfg && !wr_run) begin
          state_next = keypad_pkg::st_sleep;
        end else if (idle_due) begin
          state_next = keypad_pkg::st_sleep;
        end
      end
      keypad_pkg::st_sleep: begin
        if (wr_cfg) begin
          state_next = wr_run ? keypad_pkg::st_run : keypad_pkg::st_sleep;
        end else if (autowake_reg && wake_press) begin
          state_next = keypad_pkg::st_waking;
        end
      end
      keypad_pkg::st_waking: begin
        if (wr_cfg) begin
          state_next = wr_run ? keypad_pkg::st_run : keypad_pkg::st_sleep;
        end else if (wake_done) begin
          state_next = keypad_pkg::st_run;
        end
      end
    endcase
  end

  // the fifo has no flush path here, so its contents ride through sleep
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= keypad_pkg::st_run;
    end else begin
      state_reg <= state_next;
    end
  end

  // sense is powered while waking so the wake key can debounce afterwards
  assign sense_enable  = (state_reg != keypad_pkg::st_sleep);
  assign matrix_pullup = (state_reg == keypad_pkg::st_sleep);
  assign scan_enable   = awake;

  ////////////////////////////////////////////////////////////////////////////
  // autorepeat

  logic       phase_reg;
  logic [7:0] rep_cnt_reg;
  logic       push_reg;

  wire       rep_en     = repeat_reg[keypad_pkg::REP_EN_BIT];
  wire [3:0] delay_code = repeat_reg[keypad_pkg::REP_DELAY_LSB +: keypad_pkg::REP_DELAY_W];
  wire [2:0] rate_code  = repeat_reg[keypad_pkg::REP_RATE_LSB +: keypad_pkg::REP_RATE_W];
  wire [7:0] delay_lim  = 8'(({4'h0, delay_code} + 8'h01) *
                          8'(keypad_pkg::DELAY_STEP)) - 8'h01;
  wire [7:0] rate_lim   = 8'(({5'h00, rate_code} + 8'h01) *
                          8'(keypad_pkg::RATE_STEP)) - 8'h01;
  wire [7:0] rep_lim    = phase_reg ? rate_lim : delay_lim;
  wire       rep_go     = rep_en && any_key_held && awake;
  wire       rep_hit    = ticks.debounce_tick && (rep_cnt_reg == rep_lim);

  // one shared counter for all held keys gives one code per interval
  always_ff @(posedge clk_sys) begin
    if (reset || key_event || !rep_go) begin
      rep_cnt_reg <= 8'h00;
      phase_reg   <= 1'b0;
    end else if (rep_hit) begin
      rep_cnt_reg <= 8'h00;
      phase_reg   <= 1'b1;
    end else if (ticks.debounce_tick) begin
      rep_cnt_reg <= rep_cnt_reg + 8'h01;
    end
  end

  // push strobe; the key's own code is never produced here
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      push_reg <= 1'b0;
    end else begin
      push_reg <= rep_go && !key_event && rep_hit;
    end
  end

  assign fifo_push     = push_reg;
  assign fifo_data     = keypad_pkg::REPEAT_CODE;
  assign repeat_active = rep_go;

  ////////////////////////////////////////////////////////////////////////////
  // open-drain outputs

  logic [6:0] line_oe;

  gpo_drive u_gpo (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .level_bits   (ports_reg[7:1]),
    .ports_code   (deb_reg[keypad_pkg::DEB_PORTS_LSB +: keypad_pkg::DEB_PORTS_W]),
    .int_reg_zero (int_reg_zero),
    .gpo_mode     (gpo_mode),
    .line_oe      (line_oe)
  );

  assign column_or_output_lines_out = 6'h00;
  assign column_or_output_lines_oe  = line_oe[6:1];
  assign general_output_line_out    = 1'b0;
  assign general_output_line_oe     = line_oe[0];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_ports_wr;
    reg_wr && (reg_addr == keypad_pkg::REG_PORTS);
  endsequence

  sequence s_ports_rd;
    reg_rd && !reg_wr && (reg_addr == keypad_pkg::REG_PORTS);
  endsequence

  property p_ports_readback;
    @(posedge clk_sys) disable iff (reset)
    s_ports_wr ##1 s_ports_rd |=>
      (reg_rvalid && (reg_rdata == ($past(reg_wdata, 2) & keypad_pkg::PORTS_MASK)));
  endproperty
  a_ports_readback: assert property (p_ports_readback) else $error("port readback wrong");

  property p_repeat_off;
    @(posedge clk_sys) disable iff (reset)
    !$past(rep_en) |-> !fifo_push;
  endproperty
  a_repeat_off: assert property (p_repeat_off) else $error("push while repeat disabled");

  sequence s_delay_due;
    rep_go && !key_event && !phase_reg && ticks.debounce_tick && (rep_cnt_reg == delay_lim);
  endsequence

  property p_delay_push;
    @(posedge clk_sys) disable iff (reset)
    s_delay_due |=> (fifo_push && phase_reg && (rep_cnt_reg == 8'h00));
  endproperty
  a_delay_push: assert property (p_delay_push) else $error("no push after delay");

  sequence s_rate_due;
    rep_go && !key_event && phase_reg && ticks.debounce_tick && (rep_cnt_reg == rate_lim);
  endsequence

  property p_rate_push;
    @(posedge clk_sys) disable iff (reset)
    s_rate_due |=> fifo_push;
  endproperty
  a_rate_push: assert property (p_rate_push) else $error("no push at rate");

  property p_single_push;
    @(posedge clk_sys) disable iff (reset)
    fifo_push |=> !fifo_push [*8];
  endproperty
  a_single_push: assert property (p_single_push) else $error("repeat pushes too close");

  property p_event_restart;
    @(posedge clk_sys) disable iff (reset)
    key_event |=> (!fifo_push && !phase_reg && (rep_cnt_reg == 8'h00));
  endproperty
  a_event_restart: assert property (p_event_restart) else $error("event did not restart");

  property p_host_sleep;
    @(posedge clk_sys) disable iff (reset)
    wr_cfg && !wr_run |=> (state_reg == keypad_pkg::st_sleep) && matrix_pullup && !sense_enable;
  endproperty
  a_host_sleep: assert property (p_host_sleep) else $error("sleep write ignored");

  property p_status_read;
    @(posedge clk_sys) disable iff (reset)
    reg_rd && (reg_addr == keypad_pkg::REG_CFG) |=>
      (reg_rdata[keypad_pkg::CFG_RUN_BIT] == $past(awake));
  endproperty
  a_status_read: assert property (p_status_read) else $error("sleep status misread");

  property p_autosleep;
    @(posedge clk_sys) disable iff (reset)
    awake && idle_due && !wr_cfg |=> (state_reg == keypad_pkg::st_sleep);
  endproperty
  a_autosleep: assert property (p_autosleep) else $error("autosleep missed");

  property p_wake_time;
    @(posedge clk_sys) disable iff (reset)
    $rose(state_reg == keypad_pkg::st_waking) |->
      !scan_enable [*4];
  endproperty
  a_wake_time: assert property (p_wake_time) else $error("scan before turn-on");

  property p_wake_disabled;
    @(posedge clk_sys) disable iff (reset)
    (state_reg == keypad_pkg::st_sleep) && !autowake_reg |=>
      (state_reg != keypad_pkg::st_waking);
  endproperty
  a_wake_disabled: assert property (p_wake_disabled) else $error("woke with autowake off");

  property p_idle_restart;
    @(posedge clk_sys) disable iff (reset)
    any_key_held |=> (idle_ms_reg == 14'h0000);
  endproperty
  a_idle_restart: assert property (p_idle_restart) else $error("idle timer not cleared");

endmodule
`default_nettype wire

//--- bench/host_model.sv
// Purpose: host side of the byte register port
// Assumes: one strobe per byte, answer one cycle after a read
// Notes:   released address and data are inverted, not held
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // clock
  input  wire logic       clk_sys,
  // register port
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one write strobe; a config write sleeps or wakes the device
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // read strobe; data only counts while valid is up
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge clk_sys);
    d = reg_rvalid ? reg_rdata : 8'hXX;
  endtask
endmodule
`default_nettype wire

//--- bench/keypad_repeat_sleep_gpo_bench.sv
// Purpose: self-checking bench for repeat, sleep and port drive
// Assumes: four clocks to the millisecond to keep the run short
// Notes:   seed fixed, so every run is the same
`timescale 1ns/10ps
`default_nettype none
module keypad_repeat_sleep_gpo_bench;
  localparam int CPMS = 4;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic int_reg_zero = 1'b0;
  logic key_event = 1'b0;
  logic any_key_held = 1'b0;
  logic key_wake_n = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, fifo_data, v, r;
  logic reg_wr, reg_rd, reg_rvalid, debounce_tick, scan_enable, fifo_push;
  logic repeat_active, sense_enable, matrix_pullup, general_output_line_out;
  logic general_output_line_oe;
  logic [5:0] column_or_output_lines_out, column_or_output_lines_oe;
  logic [6:0] gpo_mode;
  logic [7:0] ra [5] = '{8'h04, 8'h05, 8'h06, 8'h0A, 8'h01};
  logic [7:0] re [5] = '{8'hFE, 8'h00, 8'h07, 8'h00, 8'h82};
  int n_fail = 0;
  int n_compared = 0;
  int seed = 32;
  int ticks = 0;
  int pushes = 0;

  always #25 clk_sys = ~clk_sys;
  // debounce ticks since the last key event or push
  always @(posedge clk_sys) begin
    if (key_event || fifo_push) ticks <= 0;
    else if (debounce_tick) ticks <= ticks + 1;
    if (fifo_push) pushes <= pushes + 1;
  end

  host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  keypad_repeat_sleep_gpo #(.CYCLES_PER_MS(CPMS)) dut (.clk_sys(clk_sys), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .int_reg_zero(int_reg_zero),
    .key_event(key_event), .any_key_held(any_key_held), .debounce_tick(debounce_tick),
    .scan_enable(scan_enable), .key_wake_n(key_wake_n), .fifo_push(fifo_push),
    .fifo_data(fifo_data), .repeat_active(repeat_active), .sense_enable(sense_enable),
    .matrix_pullup(matrix_pullup), .column_or_output_lines_out(column_or_output_lines_out),
    .column_or_output_lines_oe(column_or_output_lines_oe),
    .general_output_line_out(general_output_line_out),
    .general_output_line_oe(general_output_line_oe), .gpo_mode(gpo_mode));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ports enabled from 7 downward, codes 6 and 7 both give all six
  function automatic logic [6:0] mode_exp(input logic [2:0] c, input logic z);
    int n;
    n = (c > 3'h5) ? 6 : int'(c);
    return {6'h3F << (6 - n), z};
  endfunction
  task automatic kev;
    @(posedge clk_sys);
    key_event <= 1'b1;
    @(posedge clk_sys);
    key_event <= 1'b0;
  endtask
  // next push: tick count since its cause and the code pushed
  task automatic wait_push(input int e);
    @(negedge clk_sys);
    for (int i = 0; i < 6000 && fifo_push !== 1'b1; i++) @(negedge clk_sys);
    chk("push seen", 8'h01, {7'h00, fifo_push});
    chk("repeat active", 8'h01, {7'h00, repeat_active});
    chk("repeat ticks", e[7:0], ticks[7:0]);
    chk("fifo code", 8'h7E, fifo_data);
  endtask
  task automatic lines(input logic [7:0] e);
    @(negedge clk_sys);
    chk("sleep lines", e, {5'h00, scan_enable, sense_enable, matrix_pullup});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the longest repeat sequence
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      host.rd(ra[i], r);
      chk("reset value", re[i], r);
    end
    // every ports field code with random levels and alert mode
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      int_reg_zero <= v[0];
      host.wr(8'h02, {3'(i), 5'h00});
      host.wr(8'h04, v);
      host.rd(8'h04, r);
      chk("ports read", v & 8'hFE, r);
      chk("gpo mode", {1'b0, mode_exp(3'(i), v[0])}, {1'b0, gpo_mode});
      chk("line oe", {1'b0, mode_exp(3'(i), v[0]) & ~v[7:1]},
          {1'b0, column_or_output_lines_oe, general_output_line_oe});
    end
    // random codes, then the longest delay and rate
    any_key_held <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      v = (i == 1) ? 8'hFF : 8'($random(seed)) | 8'h80;
      host.wr(8'h05, v);
      kev();
      wait_push((v[3:0] + 1) * 8);
      wait_push((v[6:4] + 1) * 4);
      wait_push((v[6:4] + 1) * 4);
      kev();
      wait_push((v[3:0] + 1) * 8);
    end
    host.wr(8'h05, 8'h00);
    v = 8'(pushes);
    repeat (1500) @(posedge clk_sys);
    chk("pushes off", v, 8'(pushes));
    chk("repeat idle", 8'h00, {7'h00, repeat_active});
    any_key_held <= 1'b0;
    host.wr(8'h01, 8'h02);
    lines(8'h01);
    host.rd(8'h01, r);
    chk("cfg asleep", 8'h02, r);
    key_wake_n <= 1'b0;
    repeat (20) @(posedge clk_sys);
    lines(8'h06);
    host.rd(8'h01, r);
    chk("cfg woken", 8'h82, r);
    key_wake_n <= 1'b1;
    host.wr(8'h01, 8'h00);
    key_wake_n <= 1'b0;
    repeat (20) @(posedge clk_sys);
    lines(8'h01);
    key_wake_n <= 1'b1;
    host.wr(8'h01, 8'h82);
    lines(8'h06);
    // 256 ms idle limit is 1024 clocks here
    host.wr(8'h06, 8'h06);
    repeat (1000) @(posedge clk_sys);
    lines(8'h06);
    repeat (100) @(posedge clk_sys);
    lines(8'h01);
    host.rd(8'h01, r);
    chk("cfg autosleep", 8'h02, r);
    conclude();
  end
endmodule
`default_nettype wire
